// ===== logic/aisp_pkg.sv
// Package: register map, field layout and types of the converter input select and pin mode block
package aisp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CH0_SEL = 8'h00;
  localparam logic [7:0] OFS_PIN_MODE_BIT_HIGH = 8'h04;
  localparam logic [7:0] OFS_PIN_MODE_BIT_LOW = 8'h08;
  localparam logic [7:0] OFS_PCFG2_LOW = 8'h0C;
  localparam logic [7:0] OFS_MOD_DIS = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CH0_SEL2 = 8'h18;
  localparam logic [1:0] RST_MOD_DIS = 2'h0;
  localparam logic [15:0] RST_CH0_SEL = 16'h0000;
  localparam logic [15:0] RST_PIN_MODE_BIT = 16'h0000;
  localparam logic [15:0] CH0_SEL_MASK = 16'h9F9F;
  localparam int SA_POS_LSB = 0;
  localparam int SA_NEG_BIT = 7;
  localparam int SB_POS_LSB = 8;
  localparam int SB_NEG_BIT = 15;
  localparam int SEL_W = 5;
  localparam int MD1_BIT = 0;
  localparam int MD2_BIT = 1;
  localparam logic [4:0] SECOND_MAX_SEL = 5'h0F;
  localparam logic [4:0] NEG_ANALOG_INPUT = 5'h01;

  typedef struct packed {
    logic [4:0] pos;
    logic neg_is_an1;
  } aisp_route_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } aisp_wb_req_s;
endpackage

// ===== logic/aisp_sel_reg.sv
// Channel select register with masked unimplemented bits and route decode
`timescale 1ns/1ps
module aisp_sel_reg import aisp_pkg::*; #(
  parameter logic [4:0] MAX_SEL = 5'h1F
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] value_o,
  output aisp_route_s route_a_o,
  output aisp_route_s route_b_o
);
  logic [15:0] value;
  logic [15:0] next_value;
  logic [4:0] sa;
  logic [4:0] sb;

  always_comb begin
    next_value = value;
    if (wr_i) begin
      next_value = wdata_i & CH0_SEL_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value <= RST_CH0_SEL;
    end else begin
      value <= next_value;
    end
  end

  // Out-of-range codes are clamped so an unsupported input is never routed
  assign sa = value[SA_POS_LSB +: SEL_W];
  assign sb = value[SB_POS_LSB +: SEL_W];
  assign route_a_o.pos = (sa > MAX_SEL) ? MAX_SEL : sa;
  assign route_b_o.pos = (sb > MAX_SEL) ? MAX_SEL : sb;
  assign route_a_o.neg_is_an1 = value[SA_NEG_BIT];
  assign route_b_o.neg_is_an1 = value[SB_NEG_BIT];
  assign value_o = value;
endmodule

// ===== logic/aisp_pin_cfg.sv
// One 16-bit pin mode configuration register
`timescale 1ns/1ps
module aisp_pin_cfg import aisp_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] value_o
);
  logic [15:0] value;
  logic [15:0] next_value;

  always_comb begin
    next_value = value;
    if (wr_i) begin
      next_value = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value <= RST_PIN_MODE_BIT;
    end else begin
      value <= next_value;
    end
  end

  assign value_o = value;
endmodule

// ===== logic/aisp_top.sv
// Converter input select and analog pin mode control with a Wishbone slave
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module aisp_top import aisp_pkg::*; #(
  parameter int NUM_INPUTS = 32,
  parameter bit TWO_CONVERTERS = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic [31:0] pin_digital_o,
  output logic [31:0] port_read_en_o,
  output logic [31:0] mux_grounded_o,
  output logic [31:0] pin_sampled_o,
  output aisp_route_s conv1_route_a_o,
  output aisp_route_s conv1_route_b_o,
  output aisp_route_s conv2_route_a_o,
  output aisp_route_s conv2_route_b_o
);
  aisp_wb_req_s req;
  logic access;
  logic ack;
  logic next_ack;
  logic err;
  logic next_err;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic hit;
  logic wr_ok;
  logic wr_sel1;
  logic wr_sel2;
  logic wr_high;
  logic wr_low1;
  logic wr_low2;
  logic wr_md;
  logic [1:0] module_disable;
  logic [1:0] next_module_disable;
  logic [15:0] sel1_value;
  logic [15:0] sel2_value;
  logic [15:0] pin_mode_bit_high;
  logic [15:0] pin_mode_bit_low1;
  logic [15:0] pin_mode_bit_low2;
  logic [31:0] present;
  logic [31:0] cfg1;
  logic [31:0] cfg2;
  logic [31:0] analog;
  logic [31:0] next_digital;
  logic [31:0] digital;
  logic [7:0] ofs;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};
  // One-cycle answer: ack only while no ack is pending, so it drops after a cycle
  assign access = req.cyc && req.stb && !ack && !err;
  assign ofs = req.adr;

  always_comb begin
    hit = 1'b1;
    case (ofs)
      OFS_CH0_SEL: hit = 1'b1;
      OFS_PIN_MODE_BIT_HIGH: hit = 1'b1;
      OFS_PIN_MODE_BIT_LOW: hit = 1'b1;
      OFS_PCFG2_LOW: hit = TWO_CONVERTERS;
      OFS_CH0_SEL2: hit = TWO_CONVERTERS;
      OFS_MOD_DIS: hit = 1'b1;
      OFS_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Writes need both low byte lanes, since every writable register fits in the low 16 bits
  assign wr_ok = access && hit && req.we && (req.sel[1:0] == 2'b11);
  assign wr_sel1 = wr_ok && (ofs == OFS_CH0_SEL);
  assign wr_sel2 = wr_ok && (ofs == OFS_CH0_SEL2) && TWO_CONVERTERS;
  assign wr_high = wr_ok && (ofs == OFS_PIN_MODE_BIT_HIGH);
  assign wr_low1 = wr_ok && (ofs == OFS_PIN_MODE_BIT_LOW);
  assign wr_low2 = wr_ok && (ofs == OFS_PCFG2_LOW);
  assign wr_md = wr_ok && (ofs == OFS_MOD_DIS);

  aisp_sel_reg #(.MAX_SEL(5'h1F)) u_sel1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel1),
    .wdata_i(req.dat[15:0]),
    .value_o(sel1_value),
    .route_a_o(conv1_route_a_o),
    .route_b_o(conv1_route_b_o)
  );

  // Second converter shares the same select layout but is limited to 0-15
  aisp_sel_reg #(.MAX_SEL(SECOND_MAX_SEL)) u_sel2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel2),
    .wdata_i(req.dat[15:0]),
    .value_o(sel2_value),
    .route_a_o(conv2_route_a_o),
    .route_b_o(conv2_route_b_o)
  );

  aisp_pin_cfg u_high (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_high),
    .wdata_i(req.dat[15:0]),
    .value_o(pin_mode_bit_high)
  );

  aisp_pin_cfg u_low1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_low1),
    .wdata_i(req.dat[15:0]),
    .value_o(pin_mode_bit_low1)
  );

  aisp_pin_cfg u_low2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_low2 && TWO_CONVERTERS),
    .wdata_i(req.dat[15:0]),
    .value_o(pin_mode_bit_low2)
  );

  always_comb begin
    next_module_disable = module_disable;
    if (wr_md) begin
      next_module_disable = req.dat[1:0];
    end
    if (!TWO_CONVERTERS) begin
      next_module_disable[MD2_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      module_disable <= RST_MOD_DIS;
    end else begin
      module_disable <= next_module_disable;
    end
  end

  // Pin mode resolution
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      present[i] = (i < NUM_INPUTS);
    end
    cfg1 = {pin_mode_bit_high, pin_mode_bit_low1};
    cfg2 = {16'hFFFF, pin_mode_bit_low2};
    // Analog only if an enabled converter asks for it; a disabled one stays out
    analog = (module_disable[MD1_BIT] ? 32'h0000_0000 : ~cfg1);
    if (TWO_CONVERTERS && !module_disable[MD2_BIT]) begin
      analog = analog | ~cfg2;
    end
    analog = analog & present;
    next_digital = ~analog;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      digital <= 32'h0000_0000;
    end else begin
      digital <= next_digital;
    end
  end

  assign pin_digital_o = digital & present;
  assign port_read_en_o = digital & present;
  assign mux_grounded_o = digital & present;
  assign pin_sampled_o = ~digital & present;

  // Bus answer
  always_comb begin
    next_ack = 1'b0;
    next_err = 1'b0;
    next_rdata = rdata;
    if (access) begin
      next_ack = hit;
      next_err = !hit;
      next_rdata = 32'h0000_0000;
      case (ofs)
        OFS_CH0_SEL: next_rdata[15:0] = sel1_value;
        OFS_PIN_MODE_BIT_HIGH: next_rdata[15:0] = pin_mode_bit_high;
        OFS_PIN_MODE_BIT_LOW: next_rdata[15:0] = pin_mode_bit_low1;
        OFS_PCFG2_LOW: next_rdata[15:0] = pin_mode_bit_low2;
        OFS_CH0_SEL2: next_rdata[15:0] = sel2_value;
        OFS_MOD_DIS: next_rdata[1:0] = module_disable;
        OFS_STATUS: next_rdata = digital;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      err <= next_err;
      rdata <= next_rdata;
    end
  end

  assign wb_ack_o = ack;
  assign wb_err_o = err;
  assign wb_dat_o = rdata;
endmodule

// ===== verification/aisp_pin_model.sv
// Far-side model: analog pins seen by the port read path and the converter mux
`timescale 1ns/1ps
module aisp_pin_model (
  input wire logic [31:0] read_en_i,
  input wire logic [31:0] grounded_i,
  input wire logic [31:0] level_i,
  output logic [31:0] port_read_o,
  output logic [31:0] conv_seen_o
);
  // A disabled read input or a grounded mux shows 0, never a stale level
  assign port_read_o = level_i & read_en_i;
  assign conv_seen_o = level_i & ~grounded_i;
endmodule

// ===== verification/aisp_checker.sv
// Checker: port-level properties of the input select and pin mode block
`timescale 1ns/1ps
module aisp_checker import aisp_pkg::*; #(
  parameter int NUM_INPUTS = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [31:0] pin_digital_o,
  input wire logic [31:0] port_read_en_o,
  input wire logic [31:0] mux_grounded_o,
  input wire logic [31:0] pin_sampled_o,
  input wire aisp_route_s conv1_route_a_o,
  input wire aisp_route_s conv2_route_a_o
);
  localparam logic [31:0] PRESENT = 32'hFFFF_FFFF >> (32 - NUM_INPUTS);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence sel_write;
    taken ##0 (wb_we_i && wb_adr_i == OFS_CH0_SEL && wb_sel_i[1:0] == 2'h3);
  endsequence
  read_en_a: assert property (port_read_en_o == pin_digital_o)
    else $error("read enable differs from digital mode");
  mux_ground_a: assert property (mux_grounded_o == pin_digital_o)
    else $error("mux ground differs from digital mode");
  sample_inverse_a: assert property (pin_sampled_o == (~pin_digital_o & PRESENT))
    else $error("sampled pins are not the analog ones");
  answer_next_a: assert property (taken |=> wb_ack_o ^ wb_err_o)
    else $error("no single answer one cycle after request");
  pulse_once_a: assert property ((wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o))
    else $error("answer longer than one cycle");
  conv2_range_a: assert property (conv2_route_a_o.pos <= SECOND_MAX_SEL)
    else $error("second converter selects above input 15");
  sel_route_a: assert property (sel_write |=>
    conv1_route_a_o.pos == $past(wb_dat_i[4:0]) &&
    conv1_route_a_o.neg_is_an1 == $past(wb_dat_i[7])) else $error("sample A route wrong");
  unimpl_zero_a: assert property (taken ##0 (!wb_we_i && wb_adr_i == OFS_CH0_SEL) |=>
    (wb_dat_o & ~{16'h0000, CH0_SEL_MASK}) == 32'h0000_0000) else $error("unused bits not 0");
endmodule
bind aisp_top aisp_checker #(.NUM_INPUTS(NUM_INPUTS)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .pin_digital_o(pin_digital_o), .port_read_en_o(port_read_en_o),
  .mux_grounded_o(mux_grounded_o), .pin_sampled_o(pin_sampled_o),
  .conv1_route_a_o(conv1_route_a_o), .conv2_route_a_o(conv2_route_a_o));

// ===== verification/aisp_top_tb.sv
// Testbench: register access, input routing and pin mode scenarios
`timescale 1ns/1ps
module aisp_top_tb import aisp_pkg::*;;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, berr, eflag;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, lvl = 32'hC3C3_3C3C;
  logic [31:0] rdat, dat_o, dig, ren, gnd, smp, prd, seen;
  aisp_route_s r1a, r1b, r2a, r2b;
  int err_count = 0, check_count = 0, cyc_n = 0;
  always #50 clk_i = ~clk_i;
  aisp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wb_err_o(berr), .pin_digital_o(dig), .port_read_en_o(ren), .mux_grounded_o(gnd),
    .pin_sampled_o(smp), .conv1_route_a_o(r1a), .conv1_route_b_o(r1b),
    .conv2_route_a_o(r2a), .conv2_route_b_o(r2b));
  aisp_pin_model u_pins (.read_en_i(ren), .grounded_i(gnd), .level_i(lvl), .port_read_o(prd),
    .conv_seen_o(seen));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // The leading edge keeps stb low for a cycle between transfers
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk_i); while (!(ack === 1'h1 || berr === 1'h1));
    rdat = dat_o;
    eflag = berr;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic pins(input logic [31:0] e);
    @(negedge clk_i);
    chk("digital", dig, e);
    chk("read path", prd, e & lvl);
    chk("converter", seen, ~e & lvl);
    xfer(1'h0, OFS_STATUS, 32'h0000_0000, 4'hF);
    chk("status", rdat, e);
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      xfer(1'h0, 8'(4 * i), 32'h0000_0000, 4'hF);
      chk("reset value", rdat, 32'h0000_0000);
    end
    chk("sampled", smp, 32'hFFFF_FFFF);
    for (int n = 0; n < 32; n++) begin
      xfer(1'h1, OFS_CH0_SEL, {16'h0, n[0], 2'h3, 5'(31 - n), ~n[0], 2'h3, 5'(n)}, 4'hF);
      chk("route a", 32'(r1a), 32'({5'(n), ~n[0]}));
      chk("route b", 32'(r1b), 32'({5'(31 - n), n[0]}));
    end
    chk("second route", 32'(r2a), 32'h0000_0000);
    xfer(1'h1, OFS_CH0_SEL2, 32'h0000_8A1F, 4'hF);
    chk("second route a", 32'(r2a), 32'h0000_001E);
    chk("second route b", 32'(r2b), 32'h0000_0015);
    xfer(1'h0, OFS_CH0_SEL2, 32'h0000_0000, 4'hF);
    chk("second select read", rdat, 32'h0000_8A1F);
    xfer(1'h0, OFS_CH0_SEL, 32'h0000_0000, 4'hF);
    chk("select read", rdat, 32'h0000_801F);
    xfer(1'h1, OFS_PIN_MODE_BIT_LOW, 32'hFFFF_A5A5, 4'hF);
    xfer(1'h1, OFS_PIN_MODE_BIT_HIGH, 32'h0000_5A5A, 4'hF);
    xfer(1'h1, OFS_PCFG2_LOW, 32'h0000_FFFF, 4'hF);
    xfer(1'h0, OFS_PIN_MODE_BIT_HIGH, 32'h0000_0000, 4'hF);
    chk("high read", rdat, 32'h0000_5A5A);
    xfer(1'h1, OFS_PIN_MODE_BIT_LOW, 32'h0000_0000, 4'hC);
    xfer(1'h0, OFS_PIN_MODE_BIT_LOW, 32'h0000_0000, 4'hF);
    chk("lane refused", rdat, 32'h0000_A5A5);
    pins(32'h5A5A_A5A5);
    xfer(1'h1, OFS_PCFG2_LOW, 32'h0000_00FF, 4'hF);
    pins(32'h5A5A_00A5);
    xfer(1'h0, OFS_PCFG2_LOW, 32'h0000_0000, 4'hF);
    chk("second low read", rdat, 32'h0000_00FF);
    xfer(1'h1, OFS_MOD_DIS, 32'h0000_0001, 4'hF);
    pins(32'hFFFF_00FF);
    xfer(1'h1, OFS_MOD_DIS, 32'h0000_0002, 4'hF);
    pins(32'h5A5A_A5A5);
    xfer(1'h1, OFS_MOD_DIS, 32'h0000_0003, 4'hF);
    pins(32'hFFFF_FFFF);
    xfer(1'h0, OFS_MOD_DIS, 32'h0000_0000, 4'hF);
    chk("disable read", rdat, 32'h0000_0003);
    // Mid-run reset must bring every pin back to analog
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    pins(32'h0000_0000);
    xfer(1'h1, 8'h1C, 32'h0000_0000, 4'hF);
    chk("unmapped", 32'(eflag), 32'h0000_0001);
    finish_test();
  end
endmodule
